// ### verilog/async_pcm_monitor_value_table.sv
// asynchronous-mode monitor that publishes coherent minor frames into a triple-buffered value table
// Summary of operation
// - passive monitor; captures stream words, never drives stream timing.
// - all selected parameters of one minor frame are published together as one set.
// - table updates only after every selected parameter of a frame arrived.
// - three buffers; completed frame swaps in while reception fills a free one.
// - slow reads see newest value only; fast reads see the same value again.
// - status shows lock, errors, and sync seen since last status read.
// - healthy locked stream reads status upper hex digit six.
`timescale 1ns/1ps
module async_pcm_monitor_value_table
	import cvt_pkg::*;
#(
	parameter int NUM_PAR_P = cvt_pkg::NUM_PAR
) (
	input  wire logic                     clk,
	input  wire logic                     rst_n,
	input  wire cvt_pkg::word_type        word_in,
	input  wire logic                     locked_in,
	input  wire logic [cvt_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                     s_axi_awvalid,
	output logic                          s_axi_awready,
	input  wire logic [31:0]              s_axi_wdata,
	input  wire logic [3:0]               s_axi_wstrb,
	input  wire logic                     s_axi_wvalid,
	output logic                          s_axi_wready,
	output logic [1:0]                    s_axi_bresp,
	output logic                          s_axi_bvalid,
	input  wire logic                     s_axi_bready,
	input  wire logic [cvt_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                     s_axi_arvalid,
	output logic                          s_axi_arready,
	output logic [31:0]                   s_axi_rdata,
	output logic [1:0]                    s_axi_rresp,
	output logic                          s_axi_rvalid,
	input  wire logic                     s_axi_rready,
	output logic                          irq
);
	import cvt_pkg::*;

	// refuse a parameter count the select register cannot cover
	if (NUM_PAR_P < 1 || NUM_PAR_P > NUM_PAR) begin : g_bad_par
		$error("NUM_PAR_P out of range");
	end

	// stream inputs come from another domain: two flops first
	word_type               w_s1_r, w_s2_r;
	logic                   lk_s1_r, lk_s2_r;
	logic                   v_d_r;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			w_s1_r  <= '0;
			w_s2_r  <= '0;
			lk_s1_r <= 1'b0;
			lk_s2_r <= 1'b0;
			v_d_r   <= 1'b0;
		end else begin
			w_s1_r  <= word_in;
			w_s2_r  <= w_s1_r;
			lk_s1_r <= locked_in;
			lk_s2_r <= lk_s1_r;
			v_d_r   <= w_s2_r.valid;
		end
	end

	// one event per valid level pulse
	logic   wstb;
	assign wstb = w_s2_r.valid & ~v_d_r;

	// tables: three banks, one word per parameter
	logic [PAR_W-1:0]       bank_r [3][NUM_PAR];
	logic [NUM_PAR-1:0]     got_r, got_nxt;
	logic [1:0]             fill_r, fill_nxt;
	logic [1:0]             pub_r, pub_nxt;
	logic [1:0]             rd_bank_r, rd_bank_nxt;
	logic                   sync_r, sync_nxt;
	logic                   err_r, err_nxt;
	logic [31:0]            ctrl_r, ctrl_nxt;
	logic [7:0]             sel_r, sel_nxt;
	logic [IRQ_W-1:0]       ist_r, ist_nxt;
	logic [IRQ_W-1:0]       ien_r, ien_nxt;
	logic [31:0]            fcnt_r, fcnt_nxt;
	logic                   frame_done;
	logic                   status_rd;
	logic                   lk_d_r;
	logic [NUM_PAR-1:0]     need;
	logic [1:0]             free_bank;

	// only selected parameters within the configured count are waited for
	genvar g;
	generate
		for (g = 0; g < NUM_PAR; g++) begin : g_need
			assign need[g] = sel_r[g] & (g < NUM_PAR_P);
		end
	endgenerate

	// free bank is not the one filling, the published one, nor the one a reader holds
	always_comb begin
		free_bank = 2'd0;
		for (int b = 2; b >= 0; b--) begin
			if (b[1:0] != fill_r && b[1:0] != pub_r && b[1:0] != rd_bank_r)
				free_bank = b[1:0];
		end
	end

	logic  active;
	assign active = ctrl_r[CTRL_EN_BIT] & ~ctrl_r[CTRL_SYNC_BIT];
	assign frame_done = active & ((got_r & need) == need) & (|need);

	always_comb begin
		got_nxt  = got_r;
		fill_nxt = fill_r;
		pub_nxt  = pub_r;
		sync_nxt = sync_r;
		err_nxt  = err_r;
		fcnt_nxt = fcnt_r;
		// whole frame complete: swap in, start a fresh free bank
		if (frame_done) begin
			pub_nxt  = fill_r;
			fill_nxt = free_bank;
			got_nxt  = '0;
			fcnt_nxt = fcnt_r + 32'd1;
		end
		if (active && wstb) begin
			if (w_s2_r.frame_start) begin
				// a partial frame is dropped, never published
				got_nxt = '0;
			end
			if (int'(w_s2_r.index) < NUM_PAR_P)
				got_nxt[w_s2_r.index] = 1'b1;
		end
		// clear on read first so a coincident sync still sets
		if (status_rd) begin
			sync_nxt = 1'b0;
			err_nxt  = 1'b0;
		end
		if (active && wstb && w_s2_r.frame_start)
			sync_nxt = 1'b1;
		if (active && wstb && w_s2_r.error)
			err_nxt = 1'b1;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			got_r  <= '0;
			fill_r <= 2'd0;
			pub_r  <= 2'd1;
			sync_r <= 1'b0;
			err_r  <= 1'b0;
			fcnt_r <= '0;
			lk_d_r <= 1'b0;
		end else begin
			got_r  <= got_nxt;
			fill_r <= fill_nxt;
			pub_r  <= pub_nxt;
			sync_r <= sync_nxt;
			err_r  <= err_nxt;
			fcnt_r <= fcnt_nxt;
			lk_d_r <= lk_s2_r;
		end
	end

	// data array: no reset needed, newest write simply overwrites
	always_ff @(posedge clk) begin
		if (active && wstb && int'(w_s2_r.index) < NUM_PAR_P)
			bank_r[fill_r][w_s2_r.index] <= w_s2_r.data;
	end

	// axi4-lite slave
	logic                   aw_h_r, aw_h_nxt, w_h_r, w_h_nxt;
	logic [ADDR_W-1:0]      awa_r, awa_nxt;
	logic [31:0]            wd_r, wd_nxt;
	logic                   bv_r, bv_nxt, rv_r, rv_nxt;
	logic [1:0]             br_r, br_nxt, rr_r, rr_nxt;
	logic [31:0]            rd_r, rd_nxt;
	logic                   irq_r, irq_nxt;
	logic                   awrdy_r, wrdy_r, arrdy_r;
	logic                   do_wr, do_rd;
	logic [ADDR_W-1:0]      ra;

	assign do_wr = aw_h_r & w_h_r & ~bv_r;
	assign do_rd = s_axi_arvalid & ~rv_r;
	assign ra    = s_axi_araddr;
	assign status_rd = do_rd && ra == OFF_STATUS;

	always_comb begin
		aw_h_nxt  = aw_h_r;
		w_h_nxt   = w_h_r;
		awa_nxt   = awa_r;
		wd_nxt    = wd_r;
		bv_nxt    = bv_r;
		br_nxt    = br_r;
		rv_nxt    = rv_r;
		rr_nxt    = rr_r;
		rd_nxt    = rd_r;
		ctrl_nxt  = ctrl_r;
		sel_nxt   = sel_r;
		ien_nxt   = ien_r;
		ist_nxt   = ist_r;
		rd_bank_nxt = pub_r;
		if (s_axi_awvalid && !aw_h_r) begin
			aw_h_nxt = 1'b1;
			awa_nxt  = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_h_r) begin
			w_h_nxt = 1'b1;
			wd_nxt  = s_axi_wdata;
		end
		if (do_wr) begin
			aw_h_nxt = 1'b0;
			w_h_nxt  = 1'b0;
			bv_nxt   = 1'b1;
			br_nxt   = RESP_OKAY;
			case (awa_r)
				OFF_CTRL:     ctrl_nxt = wd_r;
				OFF_SELECT:   sel_nxt  = wd_r[7:0];
				OFF_IRQ_EN:   ien_nxt  = wd_r[IRQ_W-1:0];
				OFF_IRQ_CLR:  ist_nxt  = ist_r & ~wd_r[IRQ_W-1:0];
				default:      br_nxt   = RESP_SLVERR;
			endcase
		end
		if (bv_r && s_axi_bready)
			bv_nxt = 1'b0;
		// events set after the clear so they win
		if (frame_done)
			ist_nxt[IRQ_FRAME_BIT] = 1'b1;
		if (active && wstb && w_s2_r.error)
			ist_nxt[IRQ_ERR_BIT] = 1'b1;
		if (lk_s2_r != lk_d_r)
			ist_nxt[IRQ_LOCK_BIT] = 1'b1;
		if (do_rd) begin
			rv_nxt = 1'b1;
			rr_nxt = RESP_OKAY;
			rd_nxt = '0;
			// table read from the published bank, latched for this access only
			if (ra >= OFF_TABLE && ra < OFF_TABLE + ADDR_W'(4 * NUM_PAR_P)) begin
				rd_nxt[PAR_W-1:0] = bank_r[pub_r][ra[IDX_W+1:2]];
			end else begin
				case (ra)
					OFF_STATUS: begin
						rd_nxt[ST_ERR_BIT]  = err_r;
						rd_nxt[ST_LOCK_BIT] = lk_s2_r;
						rd_nxt[ST_SYNC_BIT] = sync_r;
						rd_nxt[ST_BANK_LSB +: 2] = pub_r;
					end
					OFF_CTRL:      rd_nxt = ctrl_r;
					OFF_SELECT:    rd_nxt[7:0] = sel_r;
					OFF_IRQ_STAT:  rd_nxt[IRQ_W-1:0] = ist_r;
					OFF_IRQ_EN:    rd_nxt[IRQ_W-1:0] = ien_r;
					OFF_FRAME_CNT: rd_nxt = fcnt_r;
					default:       rr_nxt = RESP_SLVERR;
				endcase
			end
		end
		if (rv_r && s_axi_rready)
			rv_nxt = 1'b0;
		irq_nxt = |(ist_nxt & ien_nxt);
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			aw_h_r  <= 1'b0;
			w_h_r   <= 1'b0;
			awa_r   <= '0;
			wd_r    <= '0;
			bv_r    <= 1'b0;
			br_r    <= RESP_OKAY;
			rv_r    <= 1'b0;
			rr_r    <= RESP_OKAY;
			rd_r    <= '0;
			ctrl_r  <= CTRL_RESET;
			sel_r   <= SELECT_RESET;
			ien_r   <= '0;
			ist_r   <= '0;
			irq_r   <= 1'b0;
			rd_bank_r <= 2'd1;
			awrdy_r <= 1'b1;
			wrdy_r  <= 1'b1;
			arrdy_r <= 1'b1;
		end else begin
			aw_h_r  <= aw_h_nxt;
			w_h_r   <= w_h_nxt;
			awa_r   <= awa_nxt;
			wd_r    <= wd_nxt;
			bv_r    <= bv_nxt;
			br_r    <= br_nxt;
			rv_r    <= rv_nxt;
			rr_r    <= rr_nxt;
			rd_r    <= rd_nxt;
			ctrl_r  <= ctrl_nxt;
			sel_r   <= sel_nxt;
			ien_r   <= ien_nxt;
			ist_r   <= ist_nxt;
			irq_r   <= irq_nxt;
			rd_bank_r <= rd_bank_nxt;
			awrdy_r <= ~aw_h_nxt;
			wrdy_r  <= ~w_h_nxt;
			arrdy_r <= ~rv_nxt;
		end
	end

	// readies kept in their own flops so every output leaves a register
	assign s_axi_awready = awrdy_r;
	assign s_axi_wready  = wrdy_r;
	assign s_axi_bvalid  = bv_r;
	assign s_axi_bresp   = br_r;
	assign s_axi_arready = arrdy_r;
	assign s_axi_rvalid  = rv_r;
	assign s_axi_rresp   = rr_r;
	assign s_axi_rdata   = rd_r;
	assign irq           = irq_r;
endmodule // async_pcm_monitor_value_table

// ### verilog/cvt_pkg.sv
// shared constants and carriers for the asynchronous telemetry value table
package cvt_pkg;
	localparam int          ADDR_W         = 12;
	localparam int          DATA_W         = 32;
	localparam int          PAR_W          = 10;
	localparam int          NUM_PAR        = 8;
	localparam int          IDX_W          = 3;
	// register byte offsets
	localparam logic [11:0] OFF_STATUS     = 12'h000;
	localparam logic [11:0] OFF_CTRL       = 12'h004;
	localparam logic [11:0] OFF_SELECT     = 12'h008;
	localparam logic [11:0] OFF_IRQ_STAT   = 12'h00c;
	localparam logic [11:0] OFF_IRQ_EN     = 12'h010;
	localparam logic [11:0] OFF_IRQ_CLR    = 12'h014;
	localparam logic [11:0] OFF_FRAME_CNT  = 12'h018;
	localparam logic [11:0] OFF_TABLE      = 12'h100;
	// status word fields: upper digit reads 6 when healthy
	localparam int          ST_SYNC_BIT    = 13;
	localparam int          ST_LOCK_BIT    = 14;
	localparam int          ST_ERR_BIT     = 15;
	localparam int          ST_BANK_LSB    = 0;
	// control fields
	localparam int          CTRL_EN_BIT    = 0;
	localparam int          CTRL_SYNC_BIT  = 1;
	localparam logic [31:0] CTRL_RESET     = 32'h0000_0001;
	localparam logic [7:0]  SELECT_RESET   = 8'hff;
	// interrupt event bits
	localparam int          IRQ_FRAME_BIT  = 0;
	localparam int          IRQ_ERR_BIT    = 1;
	localparam int          IRQ_LOCK_BIT   = 2;
	localparam int          IRQ_W          = 3;
	localparam logic [1:0]  RESP_OKAY      = 2'b00;
	localparam logic [1:0]  RESP_SLVERR    = 2'b10;

	typedef struct packed {
		logic              valid;
		logic              frame_start;
		logic              error;
		logic [IDX_W-1:0]  index;
		logic [PAR_W-1:0]  data;
	} word_type;

	typedef struct packed {
		logic              locked;
		logic              error;
		logic              sync_seen;
	} link_status_type;
endpackage

// ### tb/async_pcm_monitor_value_table_assertions.sv
// register bus checks for the value table
`timescale 1ns/1ps
module async_pcm_monitor_value_table_assertions
	import cvt_pkg::*;
(
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic [11:0] s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_ar_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence s_w_both;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	chk_read_answer: assert property (s_ar_take |=> s_axi_rvalid)
		else $error("read not answered");
	chk_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	chk_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped early");
	chk_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped early");
	chk_write_answer: assert property (s_w_both |-> ##2 s_axi_bvalid)
		else $error("write not answered");
	chk_aw_held: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
		else $error("second write address taken");
	chk_bad_read: assert property (s_ar_take ##0 s_axi_araddr == 12'h01c |=> s_axi_rresp == RESP_SLVERR
		&& s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
	chk_status_okay: assert property (s_ar_take ##0 s_axi_araddr == OFF_STATUS |=> s_axi_rresp == RESP_OKAY)
		else $error("status read refused");
endmodule // async_pcm_monitor_value_table_assertions
bind async_pcm_monitor_value_table async_pcm_monitor_value_table_assertions u_chk (.clk, .rst_n,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
	.s_axi_bresp, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
	.s_axi_rdata, .s_axi_rresp);

// ### tb/stream_source.sv
// telemetry word source on the far side of the monitor
`timescale 1ns/1ps
module stream_source
	import cvt_pkg::*;
(
	input wire logic  clk,
	output word_type  word_out
);
	initial word_out = '0;
	// fields settle before the valid rise; scrambled once hold runs out
	task automatic send(input logic fs, input logic err, input logic [2:0] idx, input logic [9:0] d);
		@(posedge clk);
		word_out <= {1'h0, fs, err, idx, d};
		repeat (3) @(posedge clk);
		word_out.valid <= 1'h1;
		repeat (3) @(posedge clk);
		word_out.valid <= 1'h0;
		repeat (3) @(posedge clk);
		word_out[14:0] <= ~word_out[14:0];
	endtask
endmodule // stream_source

// ### tb/async_pcm_monitor_value_table_tb.sv
// self-checking bench for the value table
`timescale 1ns/1ps
module async_pcm_monitor_value_table_tb;
	import cvt_pkg::*;
	logic        clk = 1'h0;
	logic        rst_n = 1'h0;
	logic        locked_in = 1'h0;
	word_type    word_in;
	logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	logic [31:0] s_axi_rdata, got;
	logic [9:0]  pend [8], tab [8];
	logic [15:0] lfsr_r = 16'h80f7;
	int          mismatches = 0, num_checks = 0;
	always #2 clk = ~clk;
	async_pcm_monitor_value_table #(.NUM_PAR_P(8)) u_dut (.*);
	stream_source u_src (.clk(clk), .word_out(word_in));
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	// upper status digit: error, lock, sync seen, then a zero
	function automatic logic [3:0] top(input logic e, input logic l, input logic s);
		return {e, l, s, 1'h0};
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'h0;
		rsp = s_axi_bresp;
	endtask
	task automatic rd(input logic [11:0] a);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'h0;
		got = s_axi_rdata;
		rsp = s_axi_rresp;
	endtask
	task automatic rc(input logic [11:0] a, input logic [31:0] e);
		rd(a);
		chk(got, e);
	endtask
	// random payloads; index 0 carries the sync
	task automatic frame(input int n);
		for (int i = 0; i < n; i++) begin
			lfsr_r = lfsr(lfsr_r);
			pend[i] = lfsr_r[9:0];
			u_src.send(i == 0, 1'h0, i[2:0], lfsr_r[9:0]);
		end
		repeat (4) @(posedge clk);
	endtask
	task automatic chk_tab(input int n);
		for (int i = 0; i < n; i++) begin
			rc(OFF_TABLE + 12'(4 * i), {22'h0, tab[i]});
		end
	endtask
	task automatic print_verdict;
		$display("checks=%0d mismatches=%0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		print_verdict();
	end
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'h1;
		rc(OFF_CTRL, CTRL_RESET);
		rc(OFF_SELECT, 32'(SELECT_RESET));
		rc(OFF_FRAME_CNT, 32'h0);
		rd(OFF_IRQ_CLR);
		chk(rsp, RESP_SLVERR);
		rd(12'h01c);
		chk(rsp, RESP_SLVERR);
		wr(OFF_IRQ_STAT, 32'h7);
		chk(rsp, RESP_SLVERR);
		rc(OFF_IRQ_STAT, 32'h0);
		$display("reset test done");
		wr(OFF_CTRL, 32'h1);
		wr(OFF_IRQ_EN, 32'h1);
		locked_in <= 1'h1;
		frame(8);
		tab = pend;
		chk_tab(8);
		rc(OFF_FRAME_CNT, 32'h1);
		chk(irq, 1'h1);
		rd(OFF_STATUS);
		chk(got[15:12], top(1'h0, 1'h1, 1'h1));
		rd(OFF_STATUS);
		chk(got[13], 1'h0);
		$display("coherent frame test done");
		frame(5);
		chk_tab(8);
		rd(OFF_STATUS);
		chk(got[13], 1'h1);
		wr(OFF_IRQ_CLR, 32'h1);
		chk(irq, 1'h0);
		frame(8);
		frame(8);
		tab = pend;
		chk_tab(8);
		chk_tab(8);
		rc(OFF_FRAME_CNT, 32'h3);
		chk(irq, 1'h1);
		wr(OFF_IRQ_EN, 32'h0);
		chk(irq, 1'h0);
		$display("skip and stale test done");
		rd(OFF_STATUS);
		u_src.send(1'h0, 1'h1, 3'h3, 10'h2a5);
		repeat (4) @(posedge clk);
		rd(OFF_STATUS);
		chk(got[15:12], top(1'h1, 1'h1, 1'h0));
		rd(OFF_IRQ_STAT);
		chk(got[IRQ_ERR_BIT], 1'h1);
		chk(got[IRQ_LOCK_BIT], 1'h1);
		wr(OFF_SELECT, 32'h3);
		frame(2);
		tab[0] = pend[0];
		tab[1] = pend[1];
		chk_tab(2);
		wr(OFF_CTRL, 32'h3);
		frame(8);
		rc(OFF_FRAME_CNT, 32'h4);
		locked_in <= 1'h0;
		repeat (4) @(posedge clk);
		rd(OFF_STATUS);
		chk(got[ST_LOCK_BIT], 1'h0);
		$display("select and error test done");
		print_verdict();
	end
endmodule // async_pcm_monitor_value_table_tb
